// *** hdl/power_mode_pkg.sv ***
// Constants, types and decode function shared by the power mode and clock select logic.
package power_mode_pkg;

  // Oscillator control register layout.
  localparam int            CTRL_WIDTH       = 8;
  localparam int            IDLE_SELECT_BIT  = 7;
  localparam int            SOURCE_FIELD_LSB = 0;
  localparam int            SOURCE_FIELD_W   = 2;
  localparam logic [7:0]    CTRL_RESET       = 8'h00;
  localparam logic [7:0]    CTRL_WRITE_MASK  = 8'h83;

  // Source select field encodings.
  localparam logic [1:0]    FIELD_PRIMARY    = 2'h0;
  localparam logic [1:0]    FIELD_SECONDARY  = 2'h1;

  // Active clock source codes; NONE is used only while asleep.
  localparam logic [1:0]    SRC_PRIMARY      = 2'h0;
  localparam logic [1:0]    SRC_SECONDARY    = 2'h1;
  localparam logic [1:0]    SRC_INTERNAL     = 2'h2;
  localparam logic [1:0]    SRC_NONE         = 2'h3;

  // Primary oscillator configuration width and reset value.
  localparam int            PRI_CFG_WIDTH    = 4;
  localparam logic [3:0]    PRI_CFG_RESET    = 4'h0;

  // Clock transition settle time at the 25 MHz system clock.
  localparam int            CLK_PERIOD_NS    = 40;
  localparam int            TRANSITION_NS    = 80;
  localparam int            TRANSITION_CYC   = (TRANSITION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int            COUNT_WIDTH      = 8;

  typedef enum logic [6:0]
  {
    SLEEP_MODE             = 7'h01,
    PRIMARY_RUN_MODE       = 7'h02,
    SECONDARY_RUN_MODE     = 7'h04,
    INTERNAL_OSC_RUN_MODE  = 7'h08,
    PRIMARY_IDLE_MODE      = 7'h10,
    SECONDARY_IDLE_MODE    = 7'h20,
    INTERNAL_OSC_IDLE_MODE = 7'h40
  } mode_type;

  // Maps the two-bit field onto a source code; 1x selects the internal block.
  function automatic logic [1:0] field_to_source(input logic [1:0] field);
    if (field[1])
      field_to_source = SRC_INTERNAL;
    else if (field == FIELD_SECONDARY)
      field_to_source = SRC_SECONDARY;
    else
      field_to_source = SRC_PRIMARY;
  endfunction

endpackage

// *** hdl/clock_source_switch.sv ***
// Clock source switcher that waits for a running source and a settle time.
`timescale 1ns/10ps
`default_nettype none
module clock_source_switch
  import power_mode_pkg::*;
#(
  parameter int SETTLE_CYCLES = TRANSITION_CYC
)
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] requested_source,
  input  wire logic [2:0] source_ready,
  output logic      [1:0] active_source_q,
  output logic            switching_q
);

  localparam logic [COUNT_WIDTH-1:0] SETTLE_LAST = COUNT_WIDTH'(SETTLE_CYCLES - 1);

  logic [COUNT_WIDTH-1:0] settle_count_q;
  logic [1:0]             target_q;
  logic                   want_switch;

  // A source that is not running is never switched to; the old one keeps the clock.
  assign want_switch = (requested_source != active_source_q) && source_ready[requested_source];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      switching_q     <= 1'b0;
      settle_count_q  <= '0;
      target_q        <= SRC_PRIMARY;
      active_source_q <= SRC_PRIMARY;
    end
    else if (!want_switch)
    begin
      switching_q    <= 1'b0;
      settle_count_q <= '0;
    end
    else if (!switching_q || target_q != requested_source)
    begin
      // A new request restarts the settle time so no half-settled source is used.
      switching_q    <= 1'b1;
      target_q       <= requested_source;
      settle_count_q <= '0;
    end
    else if (settle_count_q == SETTLE_LAST)
    begin
      active_source_q <= target_q; // RULE8
      switching_q     <= 1'b0;
      settle_count_q  <= '0;
    end
    else
      settle_count_q <= settle_count_q + COUNT_WIDTH'(1);
  end

endmodule
`default_nettype wire

// *** hdl/power_mode_clock_select.sv ***
// Power-managed operating mode controller with clock source selection.
//
// What this block does
// RULE1 - The block is always in exactly one of seven modes: sleep, three run modes and three idle modes.
// RULE2 - In sleep both CPU and peripheral clocks are gated and no clock source is selected.
// RULE3 - Run and idle modes can use the primary, the secondary or the internal oscillator block.
// RULE4 - The control register holds the idle select in bit 7 and the source select field in bits 1:0.
// RULE5 - The source field decodes 00 as primary, 01 as secondary and 1x as the internal block.
// RULE6 - The primary source is the one named by the four-bit primary configuration, held fixed after reset.
// RULE7 - Selecting the internal block enables its main oscillator, postscaler and low-frequency oscillator.
// RULE8 - A change of the source field switches the clock to the new source once that source runs and settles.
// RULE9 - Only a sleep instruction moves the block from a run mode into an idle or sleep mode.
// RULE10 - The idle select value held when the sleep instruction executes picks idle or sleep.
// RULE11 - With idle select at 0 a sleep instruction enters sleep with all clocks stopped.
// RULE12 - With idle select at 1 a sleep instruction gates the CPU while peripherals keep their source.
// RULE13 - Outside sleep instructions the block runs with CPU and peripherals clocked; field 00 is full power.
// RULE14 - Software may change only the field, or change the idle bit and issue sleep, or just issue sleep, to change mode.
// RULE15 - A wake event returns to the run mode of the current source field and restarts the CPU clock.
`timescale 1ns/10ps
`default_nettype none
module power_mode_clock_select
  import power_mode_pkg::*;
#(
  parameter int SETTLE_CYCLES = TRANSITION_CYC
)
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ctrl_write,
  input  wire logic [CTRL_WIDTH-1:0]    ctrl_write_data,
  input  wire logic                     sleep_exec,
  input  wire logic                     wake_event,
  input  wire logic [PRI_CFG_WIDTH-1:0] primary_osc_config,
  input  wire logic [2:0]               source_ready,
  output logic      [CTRL_WIDTH-1:0]    oscillator_control_reg,
  output mode_type                      mode_q,
  output logic                          cpu_clk_en_q,
  output logic                          periph_clk_en_q,
  output logic      [1:0]               clock_source_q,
  output logic                          internal_block_en_q,
  output logic      [PRI_CFG_WIDTH-1:0] primary_osc_config_q,
  output logic                          switching_q
);

  logic                 cpu_idle_select;
  logic [1:0]           clock_source_select;
  logic [1:0]           requested_source;
  logic [1:0]           active_source;
  logic                 cfg_loaded_q;
  logic                 asleep;
  logic                 in_run;
  mode_type             mode_d;

  assign cpu_idle_select     = oscillator_control_reg[IDLE_SELECT_BIT];                   // RULE4
  assign clock_source_select = oscillator_control_reg[SOURCE_FIELD_LSB +: SOURCE_FIELD_W]; // RULE4
  assign requested_source    = field_to_source(clock_source_select);                      // RULE5

  // Unimplemented bits are masked so they always read as zero.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      oscillator_control_reg <= CTRL_RESET;
    else if (ctrl_write)
      oscillator_control_reg <= ctrl_write_data & CTRL_WRITE_MASK; // RULE4
  end

  // The configuration is a strap, so it is caught by the first clock after reset release.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_loaded_q         <= 1'b0;
      primary_osc_config_q <= PRI_CFG_RESET;
    end
    else if (!cfg_loaded_q)
    begin
      cfg_loaded_q         <= 1'b1;
      primary_osc_config_q <= primary_osc_config; // RULE6
    end
  end

  clock_source_switch #(
    .SETTLE_CYCLES    (SETTLE_CYCLES)
  ) u_switch (
    .clk              (clk),
    .rst              (rst),
    .requested_source (requested_source),
    .source_ready     (source_ready),
    .active_source_q  (active_source),
    .switching_q      (switching_q)
  );

  assign asleep = (mode_q == SLEEP_MODE);
  assign in_run = (mode_q == PRIMARY_RUN_MODE) || (mode_q == SECONDARY_RUN_MODE)
                  || (mode_q == INTERNAL_OSC_RUN_MODE);

  // Run mode code for a clock source; two branches of the mode logic share it.
  function automatic mode_type run_mode_of(input logic [1:0] src);
    case (src)
      SRC_SECONDARY: run_mode_of = SECONDARY_RUN_MODE;
      SRC_INTERNAL:  run_mode_of = INTERNAL_OSC_RUN_MODE;
      default:       run_mode_of = PRIMARY_RUN_MODE;
    endcase
  endfunction

  function automatic mode_type idle_mode_of(input logic [1:0] src);
    case (src)
      SRC_SECONDARY: idle_mode_of = SECONDARY_IDLE_MODE;
      SRC_INTERNAL:  idle_mode_of = INTERNAL_OSC_IDLE_MODE;
      default:       idle_mode_of = PRIMARY_IDLE_MODE;
    endcase
  endfunction

  // Run and idle modes are named from the source that really drives the clock, except on wake, which names the run mode from the field.
  always_comb
  begin
    mode_d = mode_q;
    if (in_run)
    begin
      if (sleep_exec && !cpu_idle_select)          // RULE9 RULE10
        mode_d = SLEEP_MODE;                       // RULE11
      else if (sleep_exec)
        mode_d = idle_mode_of(active_source);      // RULE12
      else
        mode_d = run_mode_of(active_source);       // RULE3 RULE13
    end
    else if (wake_event)
    begin
      // Waking uses the current field; the switcher still moves the clock if it differs.
      mode_d = run_mode_of(requested_source);      // RULE15
    end
    else if (!asleep)
    begin
      // Idle follows the active source, so a switch that finishes while idle is shown.
      mode_d = idle_mode_of(active_source);        // RULE12
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mode_q <= PRIMARY_RUN_MODE;
    else
      mode_q <= mode_d; // RULE1
  end

  // Gating outputs are computed from the next mode so they change in step with mode_q.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cpu_clk_en_q        <= 1'b1;
      periph_clk_en_q     <= 1'b1;
      clock_source_q      <= SRC_PRIMARY;
      internal_block_en_q <= 1'b0;
    end
    else if (mode_d == SLEEP_MODE)
    begin
      cpu_clk_en_q        <= 1'b0; // RULE2
      periph_clk_en_q     <= 1'b0; // RULE2
      clock_source_q      <= SRC_NONE;
      internal_block_en_q <= 1'b0;
    end
    else
    begin
      cpu_clk_en_q        <= (mode_d == PRIMARY_RUN_MODE) || (mode_d == SECONDARY_RUN_MODE)
                             || (mode_d == INTERNAL_OSC_RUN_MODE); // RULE13 RULE15
      periph_clk_en_q     <= 1'b1;
      clock_source_q      <= active_source;
      internal_block_en_q <= (active_source == SRC_INTERNAL); // RULE7
    end
  end

  localparam int SWITCH_MAX = 12;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  mode_one_hot_a: assert property ($onehot(mode_q)) // RULE1
    else $error("mode is not one-hot");

  sleep_gating_a: assert property (asleep |-> !cpu_clk_en_q && !periph_clk_en_q && clock_source_q == SRC_NONE) // RULE2
    else $error("clocks not stopped in sleep");

  ctrl_write_a: assert property (ctrl_write |=> oscillator_control_reg == ($past(ctrl_write_data) & CTRL_WRITE_MASK)) // RULE4
    else $error("control register write lost");

  field_decode_a: assert property (clock_source_select[1] |-> requested_source == SRC_INTERNAL) // RULE5
    else $error("field 1x not decoded as internal block");

  cfg_stable_a: assert property (cfg_loaded_q && $past(cfg_loaded_q) |-> $stable(primary_osc_config_q)) // RULE6
    else $error("primary configuration changed after load");

  internal_enable_a: assert property (!asleep && clock_source_q == SRC_INTERNAL |-> internal_block_en_q) // RULE7
    else $error("internal block not enabled");

  switch_done_a: assert property (in_run && !sleep_exec && requested_source != active_source
                                  && source_ready[requested_source] && $stable(requested_source)
                                  && $stable(source_ready) && !switching_q
                                  |-> ##[1:SWITCH_MAX] active_source == $past(requested_source)) // RULE8
    else $error("source switch did not complete");

  run_stays_a: assert property (in_run && !sleep_exec |=> in_run && cpu_clk_en_q && periph_clk_en_q) // RULE9 RULE13
    else $error("left run mode without sleep instruction");

  sleep_entry_a: assert property (in_run && sleep_exec && !cpu_idle_select |=> asleep) // RULE10 RULE11
    else $error("sleep not entered with idle select low");

  idle_entry_a: assert property (in_run && sleep_exec && cpu_idle_select
                                 |=> !cpu_clk_en_q && periph_clk_en_q && !asleep) // RULE12
    else $error("idle not entered with idle select high");

  wake_return_a: assert property (!in_run && wake_event
                                  |=> in_run && cpu_clk_en_q && mode_q == ($past(requested_source) == SRC_SECONDARY
                                      ? SECONDARY_RUN_MODE : $past(requested_source) == SRC_INTERNAL
                                      ? INTERNAL_OSC_RUN_MODE : PRIMARY_RUN_MODE)) // RULE15
    else $error("wake did not return to matching run mode");

  sleep_wake_c:     cover property (asleep ##1 wake_event ##1 in_run);
  idle_wake_c:      cover property (mode_q == INTERNAL_OSC_IDLE_MODE ##1 wake_event);
  secondary_run_c:  cover property (mode_q == SECONDARY_RUN_MODE);
  switch_c:         cover property (switching_q ##1 !switching_q);
  primary_idle_c:   cover property (mode_q == PRIMARY_IDLE_MODE);

endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the power mode and clock select block.
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import power_mode_pkg::*;
;
  logic           clk;
  logic           rst;
  logic           ctrl_write;
  logic           sleep_exec;
  logic           wake_event;
  logic     [7:0] ctrl_write_data;
  logic     [7:0] oscillator_control_reg;
  logic     [3:0] primary_osc_config;
  logic     [3:0] primary_osc_config_q;
  logic     [2:0] source_ready;
  mode_type       mode_q;
  logic           cpu_clk_en_q;
  logic           periph_clk_en_q;
  logic           internal_block_en_q;
  logic           switching_q;
  logic     [1:0] clock_source_q;
  int             num_errors;
  int             n_compared;
  int             cyc = 0;
  int             seed;
  logic    [31:0] d;
  logic     [1:0] s;

  power_mode_clock_select #(.SETTLE_CYCLES(2)) dut_u
  (
    .clk                    (clk),
    .rst                    (rst),
    .ctrl_write             (ctrl_write),
    .ctrl_write_data        (ctrl_write_data),
    .sleep_exec             (sleep_exec),
    .wake_event             (wake_event),
    .primary_osc_config     (primary_osc_config),
    .source_ready           (source_ready),
    .oscillator_control_reg (oscillator_control_reg),
    .mode_q                 (mode_q),
    .cpu_clk_en_q           (cpu_clk_en_q),
    .periph_clk_en_q        (periph_clk_en_q),
    .clock_source_q         (clock_source_q),
    .internal_block_en_q    (internal_block_en_q),
    .primary_osc_config_q   (primary_osc_config_q),
    .switching_q            (switching_q)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // A hang would otherwise stall the run forever; the tests need well under a thousand cycles.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [1:0] exp_src(input logic [1:0] f);
    if (f[1])
      return SRC_INTERNAL;
    return f[0] ? SRC_SECONDARY : SRC_PRIMARY;
  endfunction

  function automatic logic [7:0] exp_mode(input logic [1:0] src, input logic idle);
    return idle ? (8'h10 << src) : (8'h02 << src);
  endfunction

  task automatic wr(input logic [7:0] v);
    @(posedge clk);
    ctrl_write      <= 1'b1;
    ctrl_write_data <= v;
    @(posedge clk);
    ctrl_write <= 1'b0;
    #1;
  endtask

  task automatic pulse_sleep();
    @(posedge clk);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    #1;
  endtask

  task automatic pulse_wake();
    @(posedge clk);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    #1;
  endtask

  task automatic settle(input logic [1:0] src);
    int i;
    i = 0;
    while (i < 20 && !(clock_source_q === src && switching_q === 1'b0))
    begin
      @(posedge clk);
      #1;
      i++;
    end
    check(8'(clock_source_q), 8'(src));
  endtask

  initial
  begin
    seed = 32'h2661;
    rst = 1'b1;
    ctrl_write = 1'b0;
    sleep_exec = 1'b0;
    wake_event = 1'b0;
    ctrl_write_data = 8'h00;
    primary_osc_config = 4'hA;
    source_ready = 3'h7;
    num_errors = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    #1;
    check(oscillator_control_reg, 8'h00);
    check({1'b0, mode_q}, 8'h02);
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(8'(primary_osc_config_q), 8'h0A);
    $display("reset test done");
    // Secondary not running: the request must wait without moving the clock.
    @(posedge clk);
    source_ready <= 3'h5;
    wr(8'h01);
    repeat (6) @(posedge clk);
    #1;
    check(8'(clock_source_q), 8'(SRC_PRIMARY));
    check(8'(switching_q), 8'h00);
    @(posedge clk);
    source_ready <= 3'h7;
    repeat (2) @(posedge clk);
    #1;
    check(8'(switching_q), 8'h01);
    check(8'(clock_source_q), 8'(SRC_PRIMARY));
    settle(SRC_SECONDARY);
    $display("not ready test done");
    // Idle bit written in the same cycle as the sleep instruction applies only afterwards.
    wr(8'h00);
    settle(SRC_PRIMARY);
    @(posedge clk);
    ctrl_write      <= 1'b1;
    ctrl_write_data <= 8'h80;
    sleep_exec      <= 1'b1;
    @(posedge clk);
    ctrl_write <= 1'b0;
    sleep_exec <= 1'b0;
    #1;
    check({1'b0, mode_q}, 8'h01);
    pulse_sleep();
    check({1'b0, mode_q}, 8'h01);
    pulse_wake();
    check({1'b0, mode_q}, exp_mode(SRC_PRIMARY, 1'b0));
    pulse_wake();
    check({1'b0, mode_q}, exp_mode(SRC_PRIMARY, 1'b0));
    $display("sleep sample test done");
    for (int n = 0; n < 24; n++)
    begin
      d = $random(seed);
      // The first eight passes walk every field value with idle select both low and high.
      if (n < 8)
      begin
        d[1:0] = n[1:0];
        d[7]   = n[2];
      end
      wr(d[7:0]);
      check(oscillator_control_reg, d[7:0] & 8'h83);
      s = exp_src(d[1:0]);
      settle(s);
      check({1'b0, mode_q}, exp_mode(s, 1'b0));
      check(8'(internal_block_en_q), 8'(s == SRC_INTERNAL));
      check({6'h00, cpu_clk_en_q, periph_clk_en_q}, 8'h03);
      pulse_sleep();
      if (d[7])
      begin
        check({1'b0, mode_q}, exp_mode(s, 1'b1));
        check({6'h00, cpu_clk_en_q, periph_clk_en_q}, 8'h01);
        check(8'(clock_source_q), 8'(s));
      end
      else
      begin
        check({1'b0, mode_q}, 8'h01);
        check({6'h00, cpu_clk_en_q, periph_clk_en_q}, 8'h00);
        check(8'(clock_source_q), 8'(SRC_NONE));
      end
      pulse_wake();
      check({1'b0, mode_q}, exp_mode(s, 1'b0));
      check(8'(cpu_clk_en_q), 8'h01);
    end
    $display("random mode test done");
    print_verdict();
  end
endmodule
`default_nettype wire
